// ---- hdl/csi_chan_pkg.sv ----
// Purpose: shared constants for the clocked serial master channel
// Assumes: APB with byte addresses, 32-bit data, one register per aligned word
// Notes:   offsets, the named field positions and the level, latch and direction reset values live here
package csi_chan_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_PERIPHERAL_ENABLE_REG  = 8'h00;
  localparam logic [7:0] OFS_COMMUNICATION_CTRL_REG = 8'h04;
  localparam logic [7:0] OFS_STATIC_OUTPUT_LEVEL    = 8'h08;
  localparam logic [7:0] OFS_DATA_OUTPUT_ENABLE     = 8'h0C;
  localparam logic [7:0] OFS_CHANNEL_START          = 8'h10;
  localparam logic [7:0] OFS_CHANNEL_STOP           = 8'h14;
  localparam logic [7:0] OFS_CHANNEL_STATUS         = 8'h18;
  localparam logic [7:0] OFS_TX_DATA                = 8'h1C;
  localparam logic [7:0] OFS_RX_DATA                = 8'h20;
  localparam logic [7:0] OFS_BYTE_COUNT             = 8'h24;
  localparam logic [7:0] OFS_ERROR_FLAGS            = 8'h28;
  localparam logic [7:0] OFS_ERROR_FLAG_CLEAR_REG   = 8'h2C;
  localparam logic [7:0] OFS_PORT_LATCH             = 8'h30;
  localparam logic [7:0] OFS_PORT_DIRECTION_REG     = 8'h34;
  localparam logic [7:0] OFS_IRQ_STATUS             = 8'h38;
  localparam logic [7:0] OFS_IRQ_ENABLE             = 8'h3C;
  localparam logic [7:0] OFS_IRQ_CLEAR              = 8'h40;
  // field positions
  localparam int unsigned BIT_TRANSMIT_ENABLE = 0;
  localparam int unsigned BIT_RECEIVE_ENABLE  = 1;
  localparam int unsigned BIT_DATA_LEVEL      = 0;
  localparam int unsigned BIT_CLOCK_LEVEL     = 1;
  localparam int unsigned BIT_FRAMING_ERR     = 0;
  localparam int unsigned BIT_PARITY_ERR      = 1;
  localparam int unsigned BIT_OVERRUN_ERR     = 2;
  localparam int unsigned BIT_IRQ_XFER_END    = 0;
  localparam int unsigned BIT_IRQ_OVERRUN     = 1;
  // reset values: both static levels high, pins as inputs
  localparam logic [1:0] RST_STATIC_LEVEL = 2'h3;
  localparam logic [1:0] RST_PORT_LATCH   = 2'h3;
  localparam logic [1:0] RST_PORT_DIR     = 2'h0;
  localparam logic [7:0] FRAME_BITS       = 8'h08;
  localparam logic [7:0] SCK_HALF_DEFAULT = 8'h0A;
endpackage : csi_chan_pkg

// ---- hdl/csi_master_channel_sequencer.sv ----
// Purpose: one channel of a three-wire clocked serial master with APB registers
// Assumes: CLK_SYS_I at 250 MHz, NRST_I synchronous active low, one byte in flight
// Notes:   clock idles high, data out on falling edge, sampled on rising edge
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module csi_master_channel_sequencer
  import csi_chan_pkg::*;
#(
  parameter logic [7:0] SCK_HALF = SCK_HALF_DEFAULT
) (
  // system
  input  wire logic              CLK_SYS_I,
  input  wire logic              NRST_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // serial pins
  input  wire logic              SDI_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_N_O,
  output logic                   SCK_O,
  output logic                   SCK_OE_N_O,
  // interrupt
  output logic                   IRQ_O
);
  typedef enum logic {ENG_IDLE = 1'b0, ENG_SHIFT = 1'b1} eng_state_t;

  // register state
  logic        clk_supply, tx_en, rx_en, soe, running, tx_full, rx_full;
  logic [1:0]  static_level, port_latch, port_dir, irq_st, irq_en;
  logic [2:0]  err;
  logic [7:0]  tx_byte, rx_byte;
  logic [15:0] byte_count;
  logic        next_clk_supply, next_tx_en, next_rx_en, next_soe, next_running, next_tx_full, next_rx_full;
  logic [1:0]  next_static_level, next_port_latch, next_port_dir, next_irq_st, next_irq_en;
  logic [2:0]  next_err;
  logic [7:0]  next_tx_byte, next_rx_byte;
  logic [15:0] next_byte_count;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_sdo, next_sdo_oe_n, next_sck, next_sck_oe_n, next_irq;
  // engine state
  eng_state_t  eng, next_eng;
  logic [7:0]  shreg, next_shreg, tmr, next_tmr;
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic        sck_int, next_sck_int, out_bit, next_out_bit;
  logic        load, done;
  logic        sdi_meta, sdi_s;

  logic access, wr, rd, gated, stop_wr, lvl_wr;
  assign access  = PSEL_I & PENABLE_I & PREADY_O;
  assign gated   = clk_supply | (PADDR_I == OFS_PERIPHERAL_ENABLE_REG);
  assign wr      = access & PWRITE_I & gated;
  assign rd      = access & ~PWRITE_I & gated;
  assign stop_wr = wr & (PADDR_I == OFS_CHANNEL_STOP) & PWDATA_I[0];
  assign lvl_wr  = wr & (PADDR_I == OFS_STATIC_OUTPUT_LEVEL);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a <= OFS_IRQ_CLEAR) && (a[1:0] == 2'b00);
  endfunction : mapped

  // read mux evaluated in the setup cycle so data is registered for the access phase
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    read_word = 32'h0000_0000;
    unique case (a)
      OFS_PERIPHERAL_ENABLE_REG:  read_word[0] = clk_supply;
      OFS_COMMUNICATION_CTRL_REG: read_word[1:0] = {rx_en, tx_en};
      OFS_STATIC_OUTPUT_LEVEL:    read_word[1:0] = static_level;
      OFS_DATA_OUTPUT_ENABLE:     read_word[0] = soe;
      OFS_CHANNEL_STATUS:         read_word[3:0] = {rx_full, tx_full, (eng == ENG_SHIFT), running};
      OFS_RX_DATA:                read_word[7:0] = rx_byte;
      OFS_BYTE_COUNT:             read_word[15:0] = byte_count;
      OFS_ERROR_FLAGS:            read_word[2:0] = err;
      OFS_PORT_LATCH:             read_word[1:0] = port_latch;
      OFS_PORT_DIRECTION_REG:     read_word[1:0] = port_dir;
      OFS_IRQ_STATUS:             read_word[1:0] = irq_st;
      OFS_IRQ_ENABLE:             read_word[1:0] = irq_en;
      default:                    read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // registers, bus and pins
  always_comb begin
    logic overrun;
    overrun           = done & rx_en & rx_full & ~(rd & (PADDR_I == OFS_RX_DATA));
    next_clk_supply   = clk_supply;
    next_tx_en        = tx_en;
    next_rx_en        = rx_en;
    next_static_level = static_level;
    next_soe          = soe;
    next_running      = running;
    next_tx_byte      = tx_byte;
    next_tx_full      = tx_full & ~load;
    next_rx_byte      = rx_byte;
    next_rx_full      = rx_full;
    next_byte_count   = byte_count;
    next_err          = err;
    next_port_latch   = port_latch;
    next_port_dir     = port_dir;
    next_irq_st       = irq_st;
    next_irq_en       = irq_en;
    next_pready       = PSEL_I & ~PENABLE_I & ~PREADY_O;
    next_pslverr      = PSEL_I & ~PENABLE_I & ~PREADY_O & ~mapped(PADDR_I);
    next_prdata       = (PSEL_I & ~PENABLE_I & (clk_supply | (PADDR_I == OFS_PERIPHERAL_ENABLE_REG)))
                        ? read_word(PADDR_I) : 32'h0000_0000;
    if (rd && PADDR_I == OFS_RX_DATA) next_rx_full = 1'b0;
    if (wr) begin
      unique case (PADDR_I)
        OFS_PERIPHERAL_ENABLE_REG:  next_clk_supply = PWDATA_I[0];
        OFS_COMMUNICATION_CTRL_REG: {next_rx_en, next_tx_en} = PWDATA_I[1:0];
        OFS_STATIC_OUTPUT_LEVEL:    if (!(running && soe)) next_static_level = PWDATA_I[1:0];
        OFS_DATA_OUTPUT_ENABLE:     next_soe = PWDATA_I[0];
        OFS_CHANNEL_START:          if (PWDATA_I[0]) next_running = 1'b1;
        OFS_CHANNEL_STOP:           if (PWDATA_I[0]) next_running = 1'b0;
        OFS_TX_DATA:                if (!tx_full) begin
          next_tx_byte = PWDATA_I[7:0];
          next_tx_full = 1'b1;
        end
        OFS_BYTE_COUNT:             next_byte_count = PWDATA_I[15:0];
        OFS_ERROR_FLAG_CLEAR_REG:   next_err = err & ~PWDATA_I[2:0];
        OFS_PORT_LATCH:             next_port_latch = PWDATA_I[1:0];
        OFS_PORT_DIRECTION_REG:     next_port_dir = PWDATA_I[1:0];
        OFS_IRQ_ENABLE:             next_irq_en = PWDATA_I[1:0];
        OFS_IRQ_CLEAR:              next_irq_st = irq_st & ~PWDATA_I[1:0];
        default:                    next_irq_en = irq_en;
      endcase
    end
    // hardware events are applied after software clears, so a set wins
    if (done) begin
      next_irq_st[BIT_IRQ_XFER_END] = 1'b1;
      if (byte_count != 16'h0000) next_byte_count = byte_count - 16'h0001;
      if (rx_en) begin
        next_rx_byte = shreg;
        next_rx_full = 1'b1;
      end
    end
    if (overrun) begin
      next_err[BIT_OVERRUN_ERR]     = 1'b1;
      next_irq_st[BIT_IRQ_OVERRUN]  = 1'b1;
    end
    // a stopped channel shows static level AND port latch on both outputs
    next_sdo      = (running && soe) ? out_bit : (static_level[BIT_DATA_LEVEL] & port_latch[BIT_DATA_LEVEL]);
    next_sck      = running ? sck_int : (static_level[BIT_CLOCK_LEVEL] & port_latch[BIT_CLOCK_LEVEL]);
    next_sdo_oe_n = ~(port_dir[BIT_DATA_LEVEL] | (running & soe));
    next_sck_oe_n = ~(port_dir[BIT_CLOCK_LEVEL] | running);
    next_irq      = |(irq_st & irq_en);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      clk_supply   <= 1'b0;
      tx_en        <= 1'b0;
      rx_en        <= 1'b0;
      static_level <= RST_STATIC_LEVEL;
      soe          <= 1'b0;
      running      <= 1'b0;
      tx_byte      <= 8'h00;
      tx_full      <= 1'b0;
      rx_byte      <= 8'h00;
      rx_full      <= 1'b0;
      byte_count   <= 16'h0000;
      err          <= 3'h0;
      port_latch   <= RST_PORT_LATCH;
      port_dir     <= RST_PORT_DIR;
      irq_st       <= 2'h0;
      irq_en       <= 2'h0;
      PRDATA_O     <= 32'h0000_0000;
      PREADY_O     <= 1'b0;
      PSLVERR_O    <= 1'b0;
      SDO_O        <= 1'b1;
      SDO_OE_N_O   <= 1'b1;
      SCK_O        <= 1'b1;
      SCK_OE_N_O   <= 1'b1;
      IRQ_O        <= 1'b0;
    end else begin
      clk_supply   <= next_clk_supply;
      tx_en        <= next_tx_en;
      rx_en        <= next_rx_en;
      static_level <= next_static_level;
      soe          <= next_soe;
      running      <= next_running;
      tx_byte      <= next_tx_byte;
      tx_full      <= next_tx_full;
      rx_byte      <= next_rx_byte;
      rx_full      <= next_rx_full;
      byte_count   <= next_byte_count;
      err          <= next_err;
      port_latch   <= next_port_latch;
      port_dir     <= next_port_dir;
      irq_st       <= next_irq_st;
      irq_en       <= next_irq_en;
      PRDATA_O     <= next_prdata;
      PREADY_O     <= next_pready;
      PSLVERR_O    <= next_pslverr;
      SDO_O        <= next_sdo;
      SDO_OE_N_O   <= next_sdo_oe_n;
      SCK_O        <= next_sck;
      SCK_OE_N_O   <= next_sck_oe_n;
      IRQ_O        <= next_irq;
    end
  end

  // input synchroniser; only the second stage feeds the shifter
  always_ff @(posedge CLK_SYS_I) begin
    sdi_meta <= SDI_I;
    sdi_s    <= sdi_meta;
  end

  // shift engine: a byte starts only with transmit enabled, receive rides along
  assign load = running & tx_en & tx_full & (eng == ENG_IDLE);
  assign done = (eng == ENG_SHIFT) & running & (tmr == SCK_HALF - 8'h01) & sck_int & (bit_cnt == 3'h7);

  always_comb begin
    next_eng     = eng;
    next_shreg   = shreg;
    next_tmr     = tmr;
    next_bit_cnt = bit_cnt;
    next_sck_int = sck_int;
    next_out_bit = out_bit;
    if (!running) begin
      next_eng     = ENG_IDLE;
      next_sck_int = 1'b1;
    end else begin
      unique case (eng)
        ENG_IDLE: if (load) begin
          next_eng     = ENG_SHIFT;
          next_shreg   = tx_byte;
          next_out_bit = tx_byte[7];
          next_sck_int = 1'b0;
          next_tmr     = 8'h00;
          next_bit_cnt = 3'h0;
        end
        ENG_SHIFT: begin
          next_tmr = tmr + 8'h01;
          if (tmr == SCK_HALF - 8'h01) begin
            next_tmr = 8'h00;
            if (!sck_int) begin
              next_sck_int = 1'b1;
              next_shreg   = {shreg[6:0], sdi_s};
            end else if (bit_cnt == 3'h7) begin
              next_eng = ENG_IDLE;
            end else begin
              next_sck_int = 1'b0;
              next_out_bit = shreg[7];
              next_bit_cnt = bit_cnt + 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      eng     <= ENG_IDLE;
      shreg   <= 8'h00;
      tmr     <= 8'h00;
      bit_cnt <= 3'h0;
      sck_int <= 1'b1;
      out_bit <= 1'b1;
    end else begin
      eng     <= next_eng;
      shreg   <= next_shreg;
      tmr     <= next_tmr;
      bit_cnt <= next_bit_cnt;
      sck_int <= next_sck_int;
      out_bit <= next_out_bit;
    end
  end

  // checking helpers
  logic [3:0] rise_cnt;
  logic       sck_prev, stopped_ck;
  assign stopped_ck = static_level[BIT_CLOCK_LEVEL] & port_latch[BIT_CLOCK_LEVEL];
  always_ff @(posedge CLK_SYS_I) begin
    sck_prev <= sck_int;
    if (!NRST_I || load) rise_cnt <= 4'h0;
    else if (sck_int && !sck_prev && rise_cnt != 4'hF) rise_cnt <= rise_cnt + 4'h1;
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  sequence s_stop_taken;
    stop_wr ##1 !running;
  endsequence
  sequence s_byte_loaded;
    load ##1 (eng == ENG_SHIFT && !sck_int);
  endsequence

  AST_LEVEL_LOCK: assert property (lvl_wr && running && soe |=> $stable(static_level))
    else $error("static level changed while running with output enable");
  AST_GATED_WRITE: assert property (access && PWRITE_I && !clk_supply &&
    PADDR_I == OFS_CHANNEL_START |=> !$rose(running))
    else $error("start accepted without unit clock supply");
  AST_STOP_CLOCK: assert property (s_stop_taken |=> SCK_O == $past(stopped_ck))
    else $error("clock pin not at static level after stop");
  AST_STOPPED_AND: assert property (!running && !$past(running) |=> SDO_O ==
    $past(static_level[BIT_DATA_LEVEL] & port_latch[BIT_DATA_LEVEL]))
    else $error("stopped data pin is not level AND latch");
  AST_MSB_FIRST: assert property (s_byte_loaded |-> ##1 (SDO_O == $past(tx_byte[7], 2) || !soe))
    else $error("first bit out is not the msb");
  AST_EIGHT_EDGES: assert property (done |-> rise_cnt == 4'h8)
    else $error("byte did not take eight clock edges");
  AST_RX_STORE: assert property (done && rx_en |=> rx_full && rx_byte == $past(shreg))
    else $error("received byte not stored");
  AST_ERR_CLEAR: assert property (wr && PADDR_I == OFS_ERROR_FLAG_CLEAR_REG &&
    PWDATA_I[BIT_OVERRUN_ERR] && !done |=> !err[BIT_OVERRUN_ERR])
    else $error("overrun flag not cleared by write one");
  AST_IRQ_LEVEL: assert property (##1 IRQ_O == |($past(irq_st) & $past(irq_en)))
    else $error("interrupt output does not follow enabled status");
  AST_APB_READY: assert property (PSEL_I && !PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
    else $error("pready not a single cycle after setup");
endmodule : csi_master_channel_sequencer

// ---- verification/csi_serial_slave_model.sv ----
// Purpose: behavioural serial slave facing the channel, clock idles high
// Assumes: data changes on the clock fall and is sampled on the clock rise
// Notes:   after a byte the data line flips so a stale level is never mistaken for data
`timescale 1ns/1ps
module csi_serial_slave_model (
  // serial pins
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  output logic            sdi_o,
  // byte side for the bench
  input  wire logic [7:0] tx_byte_i,
  output logic [7:0]      rx_byte_o,
  output int              rx_count_o
);
  logic [7:0] shift_out;
  logic [7:0] shift_in;
  logic       in_frame;
  int         idx;
  initial begin
    sdi_o      = 1'b0;
    rx_byte_o  = 8'h00;
    rx_count_o = 0;
    idx        = 0;
    in_frame   = 1'b0;
  end
  // msb first, shifted out on the fall
  always @(negedge sck_i) begin
    if (!in_frame) begin
      shift_out = tx_byte_i;
      in_frame  = 1'b1;
    end
    sdi_o     <= shift_out[7];
    shift_out = {shift_out[6:0], 1'b0};
  end
  // 8-bit frames collected on the rise
  always @(posedge sck_i) begin
    if (in_frame) begin
      shift_in = {shift_in[6:0], sdo_i};
      idx      = idx + 1;
      if (idx == 8) begin
        idx        = 0;
        in_frame   = 1'b0;
        rx_byte_o  = shift_in;
        rx_count_o = rx_count_o + 1;
        #20 sdi_o <= ~sdi_o;
      end
    end
  end
endmodule : csi_serial_slave_model

// ---- verification/csi_master_channel_sequencer_tb_top.sv ----
// Purpose: self-checking bench for the serial master channel
// Assumes: apb answers within a few cycles; slave model on the serial pins
// Notes:   random bytes from a fixed seed; abort and pin tests run last
`timescale 1ns/1ps
module csi_master_channel_sequencer_tb_top;
  import csi_chan_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, sdi, err;
  logic [7:0]  paddr, slv_tx, b;
  logic [31:0] pwdata, rd;
  logic [31:0] prdata;
  logic        pready, pslverr, sdo, sdo_oe_n, sck, sck_oe_n, irq;
  logic [7:0]  slv_rx;
  int          slv_cnt, fail_count, n_checks, nb;
  logic [1:0]  lvl, lat;
  csi_master_channel_sequencer uut (
    .CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .SCK_O(sck), .SCK_OE_N_O(sck_oe_n), .IRQ_O(irq));
  // released lines are pulled high; data-in reaches the pin unfiltered
  csi_serial_slave_model slave (
    .sck_i(sck_oe_n ? 1'b1 : sck), .sdo_i(sdo_oe_n ? 1'b1 : sdo), .sdi_o(sdi),
    .tx_byte_i(slv_tx), .rx_byte_o(slv_rx), .rx_count_o(slv_cnt));
  always #2 clk = ~clk;
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one transfer; an idle cycle first so no strobe is assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    check("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask : rdchk
  task automatic irq_level(input logic exp);
    repeat (3) @(posedge clk);
    check("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irq_level
  // waits for the byte end, then checks the slave's byte, and the channel's received byte only when dup is set
  task automatic finish_byte(input logic [7:0] tx, input logic dup);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("irq_end", 32'h1, {31'h0, irq});
    check("slave_rx", {24'h0, tx}, {24'h0, slv_rx});
    if (dup) begin
      rdchk("rx_data", OFS_RX_DATA, {24'h0, slv_tx});
    end
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
  endtask : finish_byte
  task automatic send(input logic [7:0] tx, input logic dup);
    slv_tx = 8'($urandom);
    wr(OFS_TX_DATA, {24'h0, tx});
    finish_byte(tx, dup);
  endtask : send
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'h8bf6));
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; slv_tx = 8'h00;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdchk("gated_read", OFS_STATIC_OUTPUT_LEVEL, 32'h0000_0000);
    wr(OFS_DATA_OUTPUT_ENABLE, 32'h0000_0001);
    wr(OFS_CHANNEL_START, 32'h0000_0001);
    wr(OFS_PERIPHERAL_ENABLE_REG, 32'h0000_0001);
    rdchk("gated_start", OFS_CHANNEL_STATUS, 32'h0000_0000);
    rdchk("gated_write", OFS_DATA_OUTPUT_ENABLE, 32'h0000_0000);
    rdchk("level_reset", OFS_STATIC_OUTPUT_LEVEL, 32'h0000_0003);
    check("pins_hiz", 32'h3, {30'h0, sck_oe_n, sdo_oe_n});
    apb(1'b0, 8'h44, 32'h0000_0000);
    check("unmapped", 32'h1, {31'h0, err});
    wr(OFS_PORT_DIRECTION_REG, 32'h0000_0003);
    repeat (2) @(posedge clk);
    check("pins_init", 32'h3, {28'h0, sck_oe_n, sdo_oe_n, sck, sdo});
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    wr(OFS_COMMUNICATION_CTRL_REG, 32'h0000_0001);
    wr(OFS_DATA_OUTPUT_ENABLE, 32'h0000_0001);
    nb = 2 + $urandom_range(0, 2);
    wr(OFS_BYTE_COUNT, nb);
    // byte loaded before start must not move
    b = 8'h81;
    wr(OFS_TX_DATA, {24'h0, b});
    repeat (200) @(posedge clk);
    check("idle_before_start", 32'h0, slv_cnt);
    wr(OFS_CHANNEL_START, 32'h0000_0001);
    finish_byte(b, 1'b0);
    for (int i = 1; i < nb; i++) begin
      send(8'($urandom), 1'b0);
    end
    rdchk("count_done", OFS_BYTE_COUNT, 32'h0000_0000);
    wr(OFS_STATIC_OUTPUT_LEVEL, 32'h0000_0000);
    rdchk("level_locked", OFS_STATIC_OUTPUT_LEVEL, 32'h0000_0003);
    // mask, unmask and clear the pending byte end
    wr(OFS_TX_DATA, 32'h0000_007E);
    repeat (180) @(posedge clk);
    wr(OFS_IRQ_ENABLE, 32'h0000_0000);
    irq_level(1'b0);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    irq_level(1'b1);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    irq_level(1'b0);
    wr(OFS_CHANNEL_STOP, 32'h0000_0001);
    wr(OFS_DATA_OUTPUT_ENABLE, 32'h0000_0000);
    wr(OFS_COMMUNICATION_CTRL_REG, 32'h0000_0000);
    wr(OFS_COMMUNICATION_CTRL_REG, 32'h0000_0003);
    wr(OFS_DATA_OUTPUT_ENABLE, 32'h0000_0001);
    wr(OFS_CHANNEL_START, 32'h0000_0001);
    send(8'h00, 1'b1);
    send(8'hFF, 1'b1);
    send(8'($urandom), 1'b0);
    send(8'($urandom), 1'b0);
    rdchk("overrun", OFS_ERROR_FLAGS, 32'h0000_0004);
    wr(OFS_ERROR_FLAG_CLEAR_REG, 32'h0000_0004);
    rdchk("err_clear", OFS_ERROR_FLAGS, 32'h0000_0000);
    wr(OFS_IRQ_CLEAR, 32'h0000_0003);
    // stop in mid-byte
    wr(OFS_TX_DATA, 32'h0000_0055);
    repeat (30) @(posedge clk);
    wr(OFS_CHANNEL_STOP, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("sck_static", 32'h1, {31'h0, sck});
    apb(1'b0, OFS_CHANNEL_STATUS, 32'h0000_0000);
    check("running", 32'h0, {31'h0, rd[0]});
    wr(OFS_DATA_OUTPUT_ENABLE, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      lvl = (i == 0) ? 2'h3 : 2'($urandom);
      lat = (i == 0) ? 2'h3 : 2'($urandom);
      wr(OFS_STATIC_OUTPUT_LEVEL, {30'h0, lvl});
      wr(OFS_PORT_LATCH, {30'h0, lat});
      repeat (3) @(posedge clk);
      check("pins_and", {30'h0, lvl & lat}, {30'h0, sck, sdo});
    end
    conclude();
  end
endmodule : csi_master_channel_sequencer_tb_top
